// >>> eeti_top.sv
// two-wire serial target front end of a byte-wide eeprom
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// RULE_01: sample data on scl rising, change driven data after scl falling.
// RULE_02: sda is only pulled low or released, never driven high.
// RULE_03: write protect high inhibits array writes; low lets writes through.
// RULE_04: array holds 512 pages of 64 bytes, 32768 bytes.
// RULE_05: 15-bit word address: upper bits page, low six bits byte.
// RULE_06: sda change while scl high is start or stop, never data.
// RULE_07: sda falling while scl high is a start; host starts each command.
// RULE_08: sda rising while scl high is a stop ending a transfer.
// RULE_09: stop after a read places the device in standby.
// RULE_10: eight-bit words; device pulls sda low on ninth clock to acknowledge.
// RULE_11: standby at power-up and after stop once internal work ends.
// RULE_12: host recovers by clocking up to nine cycles then a start.
// RULE_13: every operation opens with an address word right after start.
// RULE_14: top four address-word bits must be the one-zero preamble.
// RULE_15: next three bits match the strapped select inputs.
// RULE_16: lowest address-word bit: one reads, zero writes.
// RULE_17: match is acknowledged; mismatch is not, device returns to standby.
// RULE_18: programming runs from the write's stop for at most 5 ms.
// RULE_19: write sends two address bytes, each acknowledged; stop starts write.
// RULE_20: page write increments low six bits only, wrapping in the page.
// RULE_21: during programming inputs are ignored and no acknowledge given.
// RULE_22: reads continue with incrementing address while host acknowledges.
// RULE_23: after a mismatch stay off sda until the next start.
module eeti_top
    import eeti_pkg::*;
#(
    parameter int WR_CYC = eeti_pkg::WR_CYCLES
) (
    // clock and reset
    input  wire logic mclk_i,
    input  wire logic rst_i,
    // two-wire bus pins
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe_n_o,
    // straps
    input  wire logic wp_i,
    input  wire logic device_select_bit2_i,
    input  wire logic device_select_bit1_i,
    input  wire logic device_select_bit0_i,
    // status
    output logic      standby_o,
    output logic      write_busy_o
);
    import eeti_pkg::*;

    //------------------------------------------------------------------
    // declarations
    //------------------------------------------------------------------
    logic [5:0]        pin_meta;
    logic [5:0]        pin_sync;
    logic [1:0]        bus_prev;
    eeti_state_t       state;
    logic [1:0]        phase;
    logic [3:0]        bit_cnt;
    logic [7:0]        shreg;
    logic              rw;
    logic              ack_ok;
    logic              ack_drv;
    logic              sda_rel;
    logic [ADDR_W-1:0] addr;
    logic              wrote;
    logic              rd_pend;
    logic [PROG_W-1:0] prog_cnt;
    logic [DATA_W-1:0] mem_rdata;

    wire               s_scl;
    wire               s_sda;
    wire               s_wp;
    wire  [2:0]        s_sel;
    wire               p_scl;
    wire               p_sda;
    wire               scl_rise;
    wire               scl_fall;
    wire               start_c;
    wire               stop_c;
    wire  [7:0]        rx_byte;
    wire               byte_done;
    wire               dev_hit;
    wire               data_push;
    wire               next_ack;
    wire  [ADDR_W-1:0] next_page_addr;

    eeti_strm_if #(.W(WORD_W)) fin ();
    eeti_strm_if #(.W(WORD_W)) fout ();

    //------------------------------------------------------------------
    // address word decode
    //------------------------------------------------------------------
    function automatic logic addr_match(input logic [7:0] b,
                                        input logic [2:0] sel);
        addr_match = (b[PRE_MSB:PRE_LSB] == PREAMBLE) &&  // RULE_14
                     (b[SEL_MSB:SEL_LSB] == sel);         // RULE_15
    endfunction

    //------------------------------------------------------------------
    // pin synchronisers and edge history
    //------------------------------------------------------------------
    // two flops per pin; edges compare second stage with a third
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pin_meta <= 6'h03;
            pin_sync <= 6'h03;
            bus_prev <= 2'h3;
        end else begin
            pin_meta <= {device_select_bit0_i, device_select_bit1_i,
                         device_select_bit2_i, wp_i, scl_i, sda_i};
            pin_sync <= pin_meta;
            bus_prev <= pin_sync[1:0];
        end
    end

    // named views of the synchronised pins
    assign s_sda = pin_sync[0];
    assign s_scl = pin_sync[1];
    assign s_wp  = pin_sync[2];
    assign s_sel = {pin_sync[3], pin_sync[4], pin_sync[5]};
    assign p_sda = bus_prev[0];
    assign p_scl = bus_prev[1];

    // bus events
    assign scl_rise = s_scl && !p_scl;
    assign scl_fall = !s_scl && p_scl;
    assign start_c  = s_scl && p_scl && p_sda && !s_sda;  // RULE_07 RULE_06
    assign stop_c   = s_scl && p_scl && !p_sda && s_sda;  // RULE_08

    //------------------------------------------------------------------
    // byte receive decode
    //------------------------------------------------------------------
    assign rx_byte   = {shreg[6:0], s_sda};
    assign byte_done = (state == ST_RX) && scl_rise && (bit_cnt == 4'h7);
    assign dev_hit   = addr_match(rx_byte, s_sel);
    // protected writes never reach the array
    assign data_push = byte_done && (phase == 2'h3) && !s_wp;  // RULE_03
    // a full buffer withholds the acknowledge unless write protect is high, so the host backs off
    assign next_ack  = (phase == 2'h0) ? dev_hit :             // RULE_17
                       (phase == 2'h3) ? (fin.ready || s_wp) : 1'b1;
    // page write wraps inside the current page
    assign next_page_addr = {addr[ADDR_W-1:PAGE_W],
                             addr[PAGE_W-1:0] + 6'h01};      // RULE_20

    //------------------------------------------------------------------
    // write buffer and array
    //------------------------------------------------------------------
    assign fin.valid  = data_push;
    assign fin.data   = {addr, rx_byte};
    // reads take the array port, so draining stalls for that cycle
    assign fout.ready = !rd_pend;

    eeti_fifo #(.W(WORD_W), .D(FIFO_DEPTH)) u_fifo (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .in_s   (fin.snk),
        .out_s  (fout.src)
    );

    eeti_mem u_mem (
        .mclk_i  (mclk_i),
        .we_i    (fout.valid && fout.ready),
        .waddr_i (fout.data[WORD_W-1:DATA_W]),
        .wdata_i (fout.data[DATA_W-1:0]),
        .re_i    (rd_pend),
        .raddr_i (addr),
        .rdata_o (mem_rdata)
    );

    //------------------------------------------------------------------
    // protocol engine
    //------------------------------------------------------------------
    // start/stop override the byte engine; programming ignores the bus
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state    <= ST_IDLE;                              // RULE_11
            phase    <= 2'h0;
            bit_cnt  <= 4'h0;
            shreg    <= 8'h00;
            rw       <= 1'b0;
            ack_ok   <= 1'b0;
            ack_drv  <= 1'b0;
            sda_rel  <= 1'b1;
            addr     <= ADDR_RST;
            wrote    <= 1'b0;
            rd_pend  <= 1'b0;
            prog_cnt <= '0;
        end else begin
            rd_pend <= byte_done && (phase == 2'h0) && dev_hit &&
                       rx_byte[RW_BIT];
            if (state == ST_PROG) begin
                sda_rel <= 1'b1;                              // RULE_21
                if (prog_cnt != '0) prog_cnt <= prog_cnt - 1'b1;
                else if (!fout.valid) state <= ST_IDLE;       // RULE_11
            end else if (start_c) begin
                state   <= ST_RX;                             // RULE_13
                phase   <= 2'h0;
                bit_cnt <= 4'h0;
                sda_rel <= 1'b1;
                wrote   <= 1'b0;
            end else if (stop_c) begin
                sda_rel <= 1'b1;
                if (wrote) begin
                    state    <= ST_PROG;                      // RULE_18
                    prog_cnt <= PROG_W'(WR_CYC - 1);
                end else begin
                    state <= ST_IDLE;                         // RULE_09
                end
            end else begin
                case (state)
                    ST_RX: begin
                        if (scl_rise) begin
                            shreg   <= rx_byte;               // RULE_01
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                        if (byte_done) begin
                            state   <= ST_RX_ACK;             // RULE_10
                            ack_drv <= 1'b0;
                            ack_ok  <= next_ack;
                            case (phase)
                                2'h0: rw <= rx_byte[RW_BIT];  // RULE_16
                                2'h1: addr[ADDR_W-1:8] <= rx_byte[6:0];
                                2'h2: addr[7:0] <= rx_byte;   // RULE_05
                                default: begin
                                    if (data_push && fin.ready) begin
                                        addr  <= next_page_addr;
                                        wrote <= 1'b1;
                                    end
                                end
                            endcase
                        end
                    end
                    ST_RX_ACK: begin
                        if (scl_fall && !ack_drv) begin
                            ack_drv <= 1'b1;
                            sda_rel <= !ack_ok;               // RULE_10
                        end else if (scl_fall) begin
                            bit_cnt <= 4'h0;
                            if (!ack_ok) begin
                                sda_rel <= 1'b1;
                                state   <= ST_IDLE;           // RULE_23
                            end else if (phase == 2'h0 && rw) begin
                                shreg   <= mem_rdata;
                                sda_rel <= mem_rdata[7];
                                bit_cnt <= 4'h1;
                                state   <= ST_TX;
                            end else begin
                                sda_rel <= 1'b1;
                                state   <= ST_RX;             // RULE_19
                                if (phase != 2'h3) phase <= phase + 2'h1;
                            end
                        end
                    end
                    ST_TX: begin
                        if (scl_fall && bit_cnt == 4'h8) begin
                            sda_rel <= 1'b1;
                            ack_drv <= 1'b0;
                            addr    <= addr + 15'h0001;       // RULE_22
                            rd_pend <= 1'b1;
                            state   <= ST_TX_ACK;
                        end else if (scl_fall) begin
                            sda_rel <= shreg[6];              // RULE_01
                            shreg   <= {shreg[6:0], 1'b0};
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                    end
                    ST_TX_ACK: begin
                        if (scl_rise) begin
                            ack_ok  <= !s_sda;
                            ack_drv <= 1'b1;
                        end else if (scl_fall && ack_drv) begin
                            if (ack_ok) begin
                                shreg   <= mem_rdata;         // RULE_22
                                sda_rel <= mem_rdata[7];
                                bit_cnt <= 4'h1;
                                state   <= ST_TX;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    //------------------------------------------------------------------
    // outputs
    //------------------------------------------------------------------
    assign sda_o        = 1'b0;                               // RULE_02
    assign sda_oe_n_o   = sda_rel;                            // RULE_02
    assign standby_o    = (state == ST_IDLE);                 // RULE_11
    assign write_busy_o = (state == ST_PROG);                 // RULE_21
endmodule // eeti_top
`default_nettype wire

// >>> eeti_pkg.sv
// constants and types shared by the two-wire eeprom target blocks
package eeti_pkg;
    //------------------------------------------------------------------
    // array organisation
    //------------------------------------------------------------------
    localparam int ADDR_W     = 15;
    localparam int PAGE_W     = 6;
    localparam int DATA_W     = 8;
    localparam int PAGES      = 512;
    localparam int PAGE_BYTES = 64;
    localparam int MEM_DEPTH  = PAGES * PAGE_BYTES;
    localparam int FIFO_DEPTH = 32;
    localparam int WORD_W     = ADDR_W + DATA_W;
    //------------------------------------------------------------------
    // address word layout
    //------------------------------------------------------------------
    localparam logic [3:0] PREAMBLE    = 4'hA;
    localparam int         PRE_MSB     = 7;
    localparam int         PRE_LSB     = 4;
    localparam int         SEL_MSB     = 3;
    localparam int         SEL_LSB     = 1;
    localparam int         RW_BIT      = 0;
    localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
    //------------------------------------------------------------------
    // timing
    //------------------------------------------------------------------
    localparam int CLK_HZ    = 100_000_000;
    localparam int T_WR_MS   = 5;
    localparam int WR_CYCLES = T_WR_MS * (CLK_HZ / 1000);
    localparam int PROG_W    = 19;
    //------------------------------------------------------------------
    // protocol states
    //------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK, ST_PROG
    } eeti_state_t;
endpackage

// >>> eeti_strm_if.sv
// valid/ready word stream between the target logic and its fifo
`timescale 1ns/100ps
`default_nettype none
interface eeti_strm_if #(parameter int W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// >>> eeti_fifo.sv
// parameterised first-in first-out buffer with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module eeti_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    // clock and reset
    input  wire logic      mclk_i,
    input  wire logic      rst_i,
    // fill and drain sides
    eeti_strm_if.snk       in_s,
    eeti_strm_if.src       out_s
);
    localparam int PW = $clog2(D);

    logic [W-1:0] store [D];
    logic [PW:0]  wr_ptr;
    logic [PW:0]  rd_ptr;
    wire          empty;
    wire          full;
    wire          do_wr;
    wire          do_rd;

    // full when pointers differ only in the wrap bit
    assign empty       = (wr_ptr == rd_ptr);
    assign full        = (wr_ptr[PW] != rd_ptr[PW]) &&
                         (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]);
    assign in_s.ready  = !full;
    assign out_s.valid = !empty;
    assign out_s.data  = store[rd_ptr[PW-1:0]];
    assign do_wr       = in_s.valid && !full;
    assign do_rd       = out_s.ready && !empty;

    // pointer update
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (do_wr) wr_ptr <= wr_ptr + 1'b1;
            if (do_rd) rd_ptr <= rd_ptr + 1'b1;
        end
    end

    // storage write
    always_ff @(posedge mclk_i) begin
        if (do_wr) store[wr_ptr[PW-1:0]] <= in_s.data;
    end
endmodule // eeti_fifo
`default_nettype wire

// >>> eeti_mem.sv
// byte array with one write port and a registered read port
`timescale 1ns/100ps
`default_nettype none
module eeti_mem
    import eeti_pkg::*;
(
    // clock
    input  wire logic              mclk_i,
    // write port
    input  wire logic              we_i,
    input  wire logic [ADDR_W-1:0] waddr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    // read port
    input  wire logic              re_i,
    input  wire logic [ADDR_W-1:0] raddr_i,
    output logic      [DATA_W-1:0] rdata_o
);
    logic [DATA_W-1:0] cells [MEM_DEPTH]; // RULE_04

    // write and registered read
    always_ff @(posedge mclk_i) begin
        if (we_i) cells[waddr_i] <= wdata_i;
        if (re_i) rdata_o <= cells[raddr_i];
    end
endmodule // eeti_mem
`default_nettype wire

// >>> eeti_host.sv
// two-wire bus host model that drives the eeprom target from outside
`timescale 1ns/100ps
`default_nettype none
module eeti_host (
    // bus lines: scl driven, sda only pulled low or released
    output logic      scl_o,
    output logic      sda_rel_o,
    input  wire logic sda_i
);
    localparam realtime Q = 31.25;   // quarter of the 125 ns bus period
    // bus idles with both lines released high
    initial begin
        scl_o     = 1'b1;
        sda_rel_o = 1'b1;
    end
    // start or repeated start: sda falls while scl is high
    task automatic start();
        #Q sda_rel_o = 1'b1;
        #Q scl_o = 1'b1;
        #Q sda_rel_o = 1'b0;
        #Q scl_o = 1'b0;
    endtask
    // stop: sda rises while scl is high, then the bus stays free
    task automatic stop();
        #Q sda_rel_o = 1'b0;
        #Q scl_o = 1'b1;
        #Q sda_rel_o = 1'b1;
        #(2 * Q);
    endtask
    // one bit: data changes only while scl is low, sampled mid high phase
    task automatic bit_xfer(input logic b, output logic s);
        #Q sda_rel_o = b;
        #Q scl_o = 1'b1;
        #Q s = sda_i;
        #Q scl_o = 1'b0;
    endtask
    // eight bits msb first, then release sda for the ninth clock
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_xfer(d[i], s);
        bit_xfer(1'b1, ack);
    endtask
    // read eight bits, then acknowledge low or leave sda high on the last
    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, s);
            d[i] = s;
        end
        bit_xfer(last, s);
    endtask
    // recovery: clock until sda is seen high, at most nine times, then start
    task automatic recover();
        logic s;
        for (int i = 0; i < 9; i++) begin
            bit_xfer(1'b1, s);
            if (s === 1'b1) break;
        end
        start();
    endtask
endmodule // eeti_host
`default_nettype wire

// >>> eeti_top_chk.sv
// concurrent checks on the pins of the two-wire eeprom target
`timescale 1ns/100ps
`default_nettype none
module eeti_top_chk #(
    parameter int WR_CYC = 50
) (
    // clock and reset
    input  wire logic mclk_i,
    input  wire logic rst_i,
    // bus pins and straps
    input  wire logic scl_i,
    input  wire logic sda_i,
    input  wire logic sda_o,
    input  wire logic sda_oe_n_o,
    input  wire logic wp_i,
    input  wire logic device_select_bit2_i,
    input  wire logic device_select_bit1_i,
    input  wire logic device_select_bit0_i,
    // status
    input  wire logic standby_o,
    input  wire logic write_busy_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // counters: scl low time and protect high time saturate; busy length wraps
    logic [3:0]  low_cnt;
    logic [11:0] wp_cnt;
    logic [19:0] busy_cnt;
    wire  [3:0]  next_low  = scl_i ? 4'h0 : low_cnt + {3'h0, low_cnt != 4'hF};
    wire  [11:0] next_wp   = wp_i ? wp_cnt + {11'h0, wp_cnt != 12'hFFF} : 12'h0;
    wire  [19:0] next_busy = write_busy_o ? busy_cnt + 20'h1 : 20'h0;
    always_ff @(posedge mclk_i) begin
        low_cnt  <= rst_i ? 4'h0 : next_low;
        wp_cnt   <= rst_i ? 12'h0 : next_wp;
        busy_cnt <= rst_i ? 20'h0 : next_busy;
    end
    // bus conditions seen on the wire
    sequence s_start; scl_i && $past(scl_i) && $fell(sda_i); endsequence
    sequence s_stop;  scl_i && $past(scl_i) && $rose(sda_i); endsequence
    property p_low_only; sda_o == 1'b0; endproperty
    property p_pull_in_low;
        $fell(sda_oe_n_o) |-> !scl_i && low_cnt inside {[4'h1:4'h6]};
    endproperty
    property p_quiet_high; $rose(scl_i) |=> $stable(sda_oe_n_o) [*3]; endproperty
    property p_ack_holds; $fell(sda_oe_n_o) |=> !sda_oe_n_o [*6]; endproperty
    property p_busy_quiet; write_busy_o |-> sda_oe_n_o && !standby_o; endproperty
    property p_busy_bound; busy_cnt <= WR_CYC + 64; endproperty
    property p_rst_idle; $fell(rst_i) |-> standby_o && !write_busy_o; endproperty
    property p_stop_idle; s_stop |-> ##[1:8] (standby_o || write_busy_o);
    endproperty
    property p_start_listen; s_start |=> sda_oe_n_o [*8]; endproperty
    property p_wp_block; $rose(write_busy_o) |-> wp_cnt < 12'h7D0; endproperty
    a_low_only: assert property (p_low_only)
        else $error("sda driven high");
    a_pull_in_low: assert property (p_pull_in_low)
        else $error("sda pulled outside scl low phase");
    a_quiet_high: assert property (p_quiet_high)
        else $error("sda drive changed while scl high");
    a_ack_holds: assert property (p_ack_holds)
        else $error("sda low drive too short");
    a_busy_quiet: assert property (p_busy_quiet)
        else $error("drive or standby during programming");
    a_busy_bound: assert property (p_busy_bound)
        else $error("programming cycle too long");
    a_rst_idle: assert property (p_rst_idle)
        else $error("not in standby after reset");
    a_stop_idle: assert property (p_stop_idle)
        else $error("no standby or programming after stop");
    a_start_listen: assert property (p_start_listen)
        else $error("sda driven during address word");
    a_wp_block: assert property (p_wp_block)
        else $error("programming started under write protect");
endmodule // eeti_top_chk
bind eeti_top eeti_top_chk #(.WR_CYC(WR_CYC)) u_chk (
    .mclk_i(mclk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .wp_i(wp_i),
    .device_select_bit2_i(device_select_bit2_i),
    .device_select_bit1_i(device_select_bit1_i),
    .device_select_bit0_i(device_select_bit0_i),
    .standby_o(standby_o), .write_busy_o(write_busy_o));
`default_nettype wire

// >>> eeti_top_tb.sv
// self-checking bench for the two-wire eeprom target with a host model
`timescale 1ns/100ps
`default_nettype none
module eeti_top_tb;
    import eeti_pkg::*;
    localparam int WR_CYC = 400;      // shortened programming time
    logic mclk, rst, wp, scl, sda_rel, sda_o, sda_oe_n, standby, wr_busy;
    logic [2:0] sel;
    logic [8:0] pg;
    logic [7:0] dat [66];
    wire        sda;
    int         error_cnt = 0;
    int         n_checks  = 0;
    string      exp_name [$];
    logic [7:0] exp_val [$];
    logic [7:0] obs_val [$];
    // wired-and bus line with pull-up
    assign sda = sda_rel & (sda_oe_n | sda_o);
    eeti_host h (.scl_o(scl), .sda_rel_o(sda_rel), .sda_i(sda));
    eeti_top #(.WR_CYC(WR_CYC)) dut (
        .mclk_i(mclk), .rst_i(rst), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .wp_i(wp),
        .device_select_bit2_i(sel[2]), .device_select_bit1_i(sel[1]),
        .device_select_bit0_i(sel[0]), .standby_o(standby),
        .write_busy_o(wr_busy));
    // 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // watcher: each observed result is compared with the oldest note
    initial begin
        forever begin
            wait (obs_val.size() > 0);
            n_checks++;
            if (obs_val[0] !== exp_val[0]) begin
                error_cnt++;
                $display("wrong value %s: expected %h, seen %h",
                         exp_name[0], exp_val[0], obs_val[0]);
            end
            void'(exp_name.pop_front());
            void'(exp_val.pop_front());
            void'(obs_val.pop_front());
        end
    end
    task automatic note(input string n, input logic [7:0] v);
        exp_name.push_back(n);
        exp_val.push_back(v);
    endtask
    task automatic look(input string n, input logic e, input logic v);
        note(n, {7'h00, e});
        obs_val.push_back({7'h00, v});
    endtask
    // send a byte and log the ninth-clock level
    task automatic tx(input logic [7:0] b, input logic ack_exp);
        logic a;
        note("ack", {7'h00, ack_exp});
        h.wr_byte(b, a);
        obs_val.push_back({7'h00, a});
    endtask
    task automatic rx(input logic [7:0] d_exp, input logic last);
        logic [7:0] d;
        note("data", d_exp);
        h.rd_byte(last, d);
        obs_val.push_back(d);
    endtask
    // write n bytes of dat, each flipped by x, from address a
    task automatic prog(input logic [14:0] a, input int n, input logic [7:0] x);
        h.start();
        tx({PREAMBLE, sel, 1'b0}, 1'b0);
        tx({1'b0, a[14:8]}, 1'b0);
        tx(a[7:0], 1'b0);
        for (int i = 0; i < n; i++) tx(dat[i] ^ x, 1'b0);
        h.stop();
    endtask
    // dummy write to load the address, then restart as a read
    task automatic seek(input logic [14:0] a);
        h.start();
        tx({PREAMBLE, sel, 1'b0}, 1'b0);
        tx({1'b0, a[14:8]}, 1'b0);
        tx(a[7:0], 1'b0);
        h.start();
        tx({PREAMBLE, sel, 1'b1}, 1'b0);
    endtask
    task automatic wait_idle();
        int k;
        k = 0;
        while (wr_busy !== 1'b0 && k < WR_CYC + 500) begin
            @(negedge mclk);
            k++;
        end
    endtask
    task automatic fin_test(input string n);
        $display("test %s ended, %0d checks so far", n, n_checks);
    endtask
    task automatic conclude();
        if (exp_val.size() != 0) error_cnt++;
        $display("checks %0d, mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // watchdog: the tests need about 120 us of bus traffic
    initial begin
        #500_000;
        error_cnt++;
        conclude();
    end
    // main sequence
    initial begin
        rst = 1'b1;
        wp  = 1'b0;
        sel = 3'h0;
        void'($urandom(38476));
        pg = 9'($urandom);
        foreach (dat[i]) dat[i] = 8'($urandom);
        repeat (16) @(negedge mclk);
        rst = 1'b0;
        sel = 3'($urandom);
        repeat (4) @(negedge mclk);
        look("standby", 1'b1, standby);
        look("busy", 1'b0, wr_busy);
        fin_test("reset");
        // mismatching address words are refused until the next start
        h.recover();
        tx({4'h5, sel, 1'b0}, 1'b1);
        tx({PREAMBLE, sel, 1'b0}, 1'b1);
        for (int i = 1; i < 8; i++) begin
            h.start();
            tx({PREAMBLE, sel, 1'b0} ^ (8'h01 << i), 1'b1);
        end
        h.stop();
        look("standby", 1'b1, standby);
        fin_test("address mismatch");
        // 66-byte page write from 0x3E rolls over inside the page
        prog({pg, 6'h3E}, 66, 8'h00);
        look("busy", 1'b1, wr_busy);
        h.start();
        tx({PREAMBLE, sel, 1'b0}, 1'b1);
        h.stop();
        wait_idle();
        look("standby", 1'b1, standby);
        fin_test("page write");
        seek({pg, 6'h3E});
        rx(dat[64], 1'b0);
        rx(dat[65], 1'b1);
        h.stop();
        look("standby", 1'b1, standby);
        seek({pg, 6'h00});
        rx(dat[2], 1'b0);
        rx(dat[3], 1'b1);
        h.stop();
        fin_test("read back");
        // protected write is acknowledged but leaves the array alone
        @(negedge mclk);
        wp = 1'b1;
        repeat (4) @(negedge mclk);
        prog({pg, 6'h3E}, 1, 8'hFF);
        look("busy", 1'b0, wr_busy);
        @(negedge mclk);
        wp = 1'b0;
        seek({pg, 6'h3E});
        rx(dat[64], 1'b1);
        h.stop();
        fin_test("write protect");
        conclude();
    end
endmodule // eeti_top_tb
`default_nettype wire
